//--- design/wdt_pkg.sv
// Package for the runaway-detection watchdog: register map, field layout, codes and timing.
// Assumes a 50 MHz system clock and an Avalon-MM slave with 32-bit data.
package wdt_pkg;

    // Register byte offsets.
    localparam logic [3:0] MODE_OFS = 4'h0;
    localparam logic [3:0] CMD_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] MASK_OFS = 4'hc;

    // Mode register fields.
    localparam int ENABLE_POS = 7;
    localparam int TSEL_LSB = 5;
    localparam int RSTCON_POS = 2;
    localparam int IDLERUN_POS = 1;

    // Reset values of the mode fields.
    localparam logic [1:0] TSEL_RST = 2'h0;
    localparam logic ENABLE_RST = 1'b1;
    localparam logic RSTCON_RST = 1'b0;
    localparam logic IDLERUN_RST = 1'b0;

    // Command codes.
    localparam logic [7:0] DISABLE_CODE = 8'hb1;
    localparam logic [7:0] CLEAR_CODE = 8'h4e;

    // Counter geometry and timeout taps.
    localparam int CNT_W = 22;
    localparam int TAP_BASE = 15;

    // Internal reset length in states, held for the longest figure.
    localparam int RST_STATES_MIN = 22;
    localparam int RST_STATES_MAX = 29;
    localparam logic [4:0] RST_LEN = 5'h1d;

    // Status bits.
    localparam int ST_TIMEOUT = 0;
    localparam int ST_RESET = 1;

    typedef enum logic [1:0] {
        RUN_MODE = 2'b00,
        LIGHT_HALT = 2'b01,
        PROG_HALT = 2'b10,
        FULL_STOP = 2'b11
    } halt_mode_t;

    typedef struct packed {
        logic watchdog_enable_bit;
        logic [1:0] timeout_select;
        logic reset_connect_bit;
        logic run_in_prog_halt_bit;
    } mode_t;

endpackage : wdt_pkg

//--- design/runaway_detect_watchdog.sv
// Runaway-detection watchdog with an Avalon-MM register slave.
// Assumes halt mode and bus release come from logic on the same clock.
//
// Contract
// - Timeout counter is a 22-stage binary counter on the system clock.
// - Two-bit select chooses a tap between 2^15 and 2^21.
// - Overflow of chosen tap raises the watchdog NMI and timeout output.
// - With reset-connect set, overflow forces internal reset of 22 to 29 states.
// - Timeout select resets to 00, the shortest time.
// - Enable bit resets to 1; counting starts without software.
// - Stopping needs enable cleared then disable code B1H; clearing alone is not enough.
// - Setting enable to 1 alone re-enables a stopped watchdog.
// - Reset-connect resets to 0; overflow gives only the interrupt.
// - Clear code 4EH zeroes the counter, which keeps counting.
// - Counter runs from the release of reset.
// - Counter stops in light-halt and full-stop modes.
// - Counter keeps counting while the bus is released.
// - In programmable halt the idle-run bit decides whether it counts.
// - Enable with select 01 gives a 2^17 cycle detection time.
`timescale 1ns/1ns
`default_nettype none
module runaway_detect_watchdog
    import wdt_pkg::*;
(
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Avalon-MM slave.
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Device state.
    input wire logic [1:0] HALT_MODE_I,
    input wire logic BUS_RELEASE_ACK_N_I,
    // Watchdog outputs.
    output logic WATCHDOG_NMI_O,
    output logic TIMEOUT_O,
    output logic INT_RESET_O,
    output logic IRQ_O
);

    function automatic logic [4:0] tap_index(input logic [1:0] sel);
        tap_index = 5'(TAP_BASE) + {2'b00, sel, 1'b0};
    endfunction : tap_index

    // Overflow is the carry out of the low stages, so the first one comes a full period after clear.
    function automatic logic [CNT_W-1:0] tap_mask(input logic [1:0] sel);
        tap_mask = (CNT_W'(1) << tap_index(sel)) - CNT_W'(1);
    endfunction : tap_mask

    mode_t mode_reg;
    logic running_reg;
    logic [CNT_W-1:0] count_reg;
    logic [4:0] rst_cnt_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic ack_reg;
    logic wr_cmd;
    logic wr_mode;
    logic rd_status;
    logic req;
    logic tick;
    logic tap_now;
    logic overflow;
    logic [1:0] status_next;

    // One wait state: a write acts at the edge where the master sees waitrequest low.
    assign req = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
    assign wr_mode = AVS_WRITE_I && ack_reg && AVS_ADDRESS_I == MODE_OFS && AVS_BYTEENABLE_I[0];
    assign wr_cmd = AVS_WRITE_I && ack_reg && AVS_ADDRESS_I == CMD_OFS && AVS_BYTEENABLE_I[0];
    assign rd_status = AVS_READ_I && ack_reg && AVS_ADDRESS_I == STATUS_OFS;

    // Halt modes gate the count; bus release does not.
    always_comb begin
        case (HALT_MODE_I)
            RUN_MODE: tick = running_reg;
            PROG_HALT: tick = running_reg && mode_reg.run_in_prog_halt_bit;
            LIGHT_HALT: tick = 1'b0;
            FULL_STOP: tick = 1'b0;
            default: tick = 1'b0;
        endcase
    end

    // All stages below the selected tap at one is the overflow; counting continues past it.
    assign tap_now = &(count_reg | ~tap_mask(mode_reg.timeout_select));
    assign overflow = tick && tap_now;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            mode_reg.watchdog_enable_bit <= ENABLE_RST;
            mode_reg.timeout_select <= TSEL_RST;
            mode_reg.reset_connect_bit <= RSTCON_RST;
            mode_reg.run_in_prog_halt_bit <= IDLERUN_RST;
        end else if (wr_mode) begin
            mode_reg.watchdog_enable_bit <= AVS_WRITEDATA_I[ENABLE_POS];
            mode_reg.timeout_select <= AVS_WRITEDATA_I[TSEL_LSB +: 2];
            mode_reg.reset_connect_bit <= AVS_WRITEDATA_I[RSTCON_POS];
            mode_reg.run_in_prog_halt_bit <= AVS_WRITEDATA_I[IDLERUN_POS];
        end
    end

    // Disabling is keyed so that runaway code cannot stop the watchdog by one write.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            running_reg <= 1'b1;
        end else if (wr_mode && AVS_WRITEDATA_I[ENABLE_POS]) begin
            running_reg <= 1'b1;
        end else if (wr_cmd && AVS_WRITEDATA_I[7:0] == DISABLE_CODE
                     && !mode_reg.watchdog_enable_bit) begin
            running_reg <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            count_reg <= '0;
        end else if (wr_cmd && AVS_WRITEDATA_I[7:0] == CLEAR_CODE) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= count_reg + 22'h1;
        end
    end

    // The internal reset is held for the longest documented figure.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            rst_cnt_reg <= 5'h0;
            INT_RESET_O <= 1'b0;
        end else if (overflow && mode_reg.reset_connect_bit) begin
            rst_cnt_reg <= RST_LEN - 5'h1;
            INT_RESET_O <= 1'b1;
        end else if (rst_cnt_reg != 5'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 5'h1;
        end else begin
            INT_RESET_O <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            WATCHDOG_NMI_O <= 1'b0;
            TIMEOUT_O <= 1'b0;
        end else begin
            WATCHDOG_NMI_O <= overflow;
            TIMEOUT_O <= overflow;
        end
    end

    // Set wins over the read-clear.
    always_comb begin
        status_next = rd_status ? 2'b00 : status_reg;
        status_next[ST_TIMEOUT] = status_next[ST_TIMEOUT] | overflow;
        status_next[ST_RESET] = status_next[ST_RESET] | (overflow & mode_reg.reset_connect_bit);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            status_reg <= 2'b00;
            mask_reg <= 2'b00;
            IRQ_O <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (AVS_WRITE_I && ack_reg && AVS_ADDRESS_I == MASK_OFS && AVS_BYTEENABLE_I[0]) begin
                mask_reg <= AVS_WRITEDATA_I[1:0];
            end
            IRQ_O <= |(status_next & mask_reg);
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            AVS_READDATA_O <= 32'h0;
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= !req;
            if (AVS_READ_I && !ack_reg) begin
                case (AVS_ADDRESS_I)
                    MODE_OFS: AVS_READDATA_O <= {24'h0, mode_reg.watchdog_enable_bit,
                        mode_reg.timeout_select, 2'b00, mode_reg.reset_connect_bit,
                        mode_reg.run_in_prog_halt_bit, running_reg};
                    STATUS_OFS: AVS_READDATA_O <= {30'h0, status_reg};
                    MASK_OFS: AVS_READDATA_O <= {30'h0, mask_reg};
                    default: AVS_READDATA_O <= 32'h0;
                endcase
            end
        end
    end

    AST_RESET_LEN: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(INT_RESET_O) |-> INT_RESET_O [*8] ##1 INT_RESET_O [*8])
        else $error("Internal reset too short.");
    AST_NO_RST_WITHOUT_CON: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        overflow && !mode_reg.reset_connect_bit && !INT_RESET_O |=> !INT_RESET_O)
        else $error("Internal reset without reset-connect.");
    AST_NMI_ON_OVF: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        overflow |=> WATCHDOG_NMI_O && TIMEOUT_O)
        else $error("Overflow without NMI.");
    AST_HALT_STOPS: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (HALT_MODE_I == LIGHT_HALT || HALT_MODE_I == FULL_STOP) && !wr_cmd
        |=> count_reg == $past(count_reg))
        else $error("Counter moved while halted.");
    AST_BUS_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        HALT_MODE_I == RUN_MODE && running_reg && !wr_cmd && !BUS_RELEASE_ACK_N_I
        |=> count_reg == $past(count_reg) + 22'h1)
        else $error("Counter stalled on bus release.");
    AST_CLEAR: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_cmd && AVS_WRITEDATA_I[7:0] == CLEAR_CODE |=> count_reg == '0)
        else $error("Clear code did not zero counter.");
    AST_KEYED_DISABLE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        running_reg && !(wr_cmd && AVS_WRITEDATA_I[7:0] == DISABLE_CODE) |=> running_reg)
        else $error("Watchdog stopped without disable code.");
    AST_REENABLE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_mode && AVS_WRITEDATA_I[ENABLE_POS] |=> running_reg)
        else $error("Enable bit did not restart watchdog.");
    AST_OTHER_CMD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_cmd && AVS_WRITEDATA_I[7:0] != CLEAR_CODE && AVS_WRITEDATA_I[7:0] != DISABLE_CODE
        && !tick |=> count_reg == $past(count_reg) && running_reg == $past(running_reg))
        else $error("Stray command had an effect.");
    AST_IDLE_RUN: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        HALT_MODE_I == PROG_HALT && !mode_reg.run_in_prog_halt_bit && !wr_cmd
        |=> $stable(count_reg))
        else $error("Counter moved in programmable halt.");
    AST_TAP: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        tick && mode_reg.timeout_select == 2'b01 |-> overflow == (count_reg[16:0] == 17'h1ffff))
        else $error("Select 01 is not 2^17.");
    AST_NMI_PULSE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        WATCHDOG_NMI_O |=> !WATCHDOG_NMI_O)
        else $error("Watchdog NMI longer than one cycle.");
    AST_STATUS_SET: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        overflow |=> status_reg[ST_TIMEOUT])
        else $error("Overflow did not set status.");
    AST_RST_CON: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        overflow && mode_reg.reset_connect_bit |=> INT_RESET_O)
        else $error("Overflow with reset-connect gave no reset.");
    AST_RESET_MODE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $fell(RST_I) |-> mode_reg.watchdog_enable_bit && running_reg
        && mode_reg.timeout_select == TSEL_RST && !mode_reg.reset_connect_bit)
        else $error("Mode not at reset values after reset.");

endmodule : runaway_detect_watchdog
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the runaway-detection watchdog and its Avalon-MM register slave.
// Assumes the package and the design are compiled first and a single 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import wdt_pkg::*;
;
    typedef struct {
        logic w;
        logic [3:0] a;
        logic [31:0] d;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [1:0] halt = 2'h0;
    logic bus_ack_n = 1'b1;
    logic [31:0] rdata;
    logic waitreq;
    logic nmi;
    logic tmo;
    logic int_rst;
    logic irq;
    logic seen;
    logic [31:0] q;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    int n;
    // Write rows carry the data to write; read rows carry the value expected back.
    row_t rows [16] = '{
        '{1'b1, MODE_OFS, 32'h00}, '{1'b0, MODE_OFS, 32'h01},
        '{1'b1, CMD_OFS, 32'h55}, '{1'b0, MODE_OFS, 32'h01},
        '{1'b1, CMD_OFS, 32'hb1}, '{1'b0, MODE_OFS, 32'h00},
        '{1'b1, MODE_OFS, 32'ha0}, '{1'b0, MODE_OFS, 32'ha1},
        '{1'b1, MODE_OFS, 32'hc0}, '{1'b0, MODE_OFS, 32'hc1},
        '{1'b1, MODE_OFS, 32'he6}, '{1'b0, MODE_OFS, 32'he7},
        '{1'b1, 4'h2, 32'hff}, '{1'b0, 4'h2, 32'h00},
        '{1'b1, MODE_OFS, 32'h84}, '{1'b0, MODE_OFS, 32'h85}
    };
    runaway_detect_watchdog uut (
        .SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .HALT_MODE_I(halt),
        .BUS_RELEASE_ACK_N_I(bus_ack_n), .WATCHDOG_NMI_O(nmi), .TIMEOUT_O(tmo),
        .INT_RESET_O(int_rst), .IRQ_O(irq)
    );
    initial begin
        forever #10 clk = ~clk;
    end
    task summarize();
        $display("Checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // No local limit: only the run's ceiling ends a wait for waitrequest.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task wait_nmi(input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (nmi !== 1'b1 && n < lim);
    endtask : wait_nmi
    // The ceiling sits above the two full timeouts and the 18000 halted cycles that the run waits through.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            failures++;
            $display("[FAIL] %0t run did not finish", $time);
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wait_nmi(34000);
        chk(32'((n >= 32760) && (n <= 32776)), 32'h1);
        chk(32'(tmo), 32'h1);
        seen = 1'b0;
        repeat (40) begin
            @(posedge clk);
            seen = seen | (int_rst !== 1'b0);
        end
        chk(32'(seen), 32'h0);
        bus(1'b0, MODE_OFS, 32'h0);
        chk(q, 32'h81);
        chk(32'(irq), 32'h0);
        bus(1'b1, MASK_OFS, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(q & 32'h3, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(q, rows[i].d);
        end
        // Halted time must not count, bus release time must.
        bus(1'b1, CMD_OFS, 32'h4e);
        t0 = cyc;
        bus_ack_n <= 1'b0;
        repeat (5000) @(posedge clk);
        bus_ack_n <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            halt <= m[1:0];
            repeat (6000) @(posedge clk);
        end
        halt <= 2'h0;
        wait_nmi(40000);
        chk(32'(((cyc - t0) >= 50760) && ((cyc - t0) <= 50776)), 32'h1);
        n = 0;
        while (int_rst !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (int_rst === 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), {27'h0, RST_LEN});
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk({29'h0, waitreq, nmi, irq}, 32'h4);
        rst <= 1'b0;
        bus(1'b0, MODE_OFS, 32'h0);
        chk(q, 32'h81);
        summarize();
    end
endmodule : testbench
`default_nettype wire
